/* File: rtl/dtcu_pkg.sv */
package dtcu_pkg;
   localparam int DW = 32;
   localparam int CW = 16;
   // register byte offsets
   localparam logic [5:0] OFS_CNT1 = 6'h00;
   localparam logic [5:0] OFS_CRA = 6'h04;
   localparam logic [5:0] OFS_CRB = 6'h08;
   localparam logic [5:0] OFS_CNT2 = 6'h0C;
   localparam logic [5:0] OFS_CKC = 6'h14;
   localparam logic [5:0] OFS_MCTRL = 6'h18;
   localparam logic [5:0] OFS_ICTRL = 6'h1C;
   localparam logic [5:0] OFS_ICLR = 6'h20;
   // mode control fields
   localparam int MC_MODE_LSB = 0;
   localparam int MC_EN = 3;
   localparam int MC_AEN = 4;
   localparam int MC_BEN = 5;
   localparam int MC_AEDG = 6;
   localparam int MC_BEDG = 7;
   localparam int MC_AOUT = 8;
   localparam int MC_PTSE = 9;
   // clock control fields: [2:0] counter one, [6:4] counter two
   localparam int CK1_LSB = 0;
   localparam int CK2_LSB = 4;
   // interrupt control: [3:0] pending (read), [7:4] enables
   localparam int IC_IEN_LSB = 4;
   localparam logic [15:0] PRESET_VAL = 16'hFFFF;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [9:0] MCTRL_RST = 10'h000;
   localparam logic [7:0] CKC_RST = 8'h00;
   localparam logic [3:0] IEN_RST = 4'h0;
   localparam logic [3:0] PND_RST = 4'h0;
   localparam logic [31:0] RD_UNMAPPED = 32'h00000000;

   typedef enum logic [2:0] {
      DTCU_M1 = 3'b000,
      DTCU_M1A = 3'b001,
      DTCU_M2 = 3'b010,
      DTCU_M3 = 3'b011,
      DTCU_M4 = 3'b100
   } dtcu_mode_t;

   typedef enum logic [2:0] {
      DTCU_CK_NONE = 3'b000,
      DTCU_CK_SYS = 3'b001,
      DTCU_CK_EXT = 3'b010,
      DTCU_CK_PULSE = 3'b011
   } dtcu_clk_t;

   typedef enum logic [1:0] {
      DTCU_BUS_IDLE = 2'b00,
      DTCU_BUS_ACK = 2'b01
   } dtcu_bus_t;
endpackage

/* File: rtl/dtcu_top.sv */
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
module dtcu_top
   import dtcu_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic timer_pin_a_i,
   input wire logic timer_pin_b_i,
   output logic timer_pin_a_o,
   output logic timer_pin_a_oe_o,
   output logic irq_line_a_o,
   output logic irq_line_b_o
);
   logic [15:0] down_counter_one_q;
   logic [15:0] down_counter_two_q;
   logic [15:0] capture_reload_a_q;
   logic [15:0] capture_reload_b_q;
   logic [9:0] mode_control_reg_q;
   logic [7:0] ckc_q;
   logic [3:0] irq_enable_q;
   logic [3:0] pending_q;
   logic pin_a_prev_q, pin_b_prev_q;
   logic armed_q;
   dtcu_bus_t bus_q;
   logic wr_acc, rd_acc;

   dtcu_mode_t mode;
   logic en, aen, ben, aedg, bedg, ptse;
   dtcu_clk_t ck1, ck2;
   assign mode = dtcu_mode_t'(mode_control_reg_q[MC_MODE_LSB +: 3]);
   assign en = mode_control_reg_q[MC_EN];
   assign aen = mode_control_reg_q[MC_AEN];
   assign ben = mode_control_reg_q[MC_BEN];
   assign aedg = mode_control_reg_q[MC_AEDG];
   assign bedg = mode_control_reg_q[MC_BEDG];
   assign ptse = mode_control_reg_q[MC_PTSE];
   assign ck1 = dtcu_clk_t'(ckc_q[CK1_LSB +: 3]);
   assign ck2 = dtcu_clk_t'(ckc_q[CK2_LSB +: 3]);

   // selected edge: 1 = rising, 0 = falling
   function automatic logic edge_hit(input logic cur, input logic prev,
                                     input logic rise);
      edge_hit = rise ? (cur & ~prev) : (~cur & prev);
   endfunction

   function automatic logic tick(input dtcu_clk_t ck, input logic ev,
                                 input logic lvl);
      case (ck)
         DTCU_CK_SYS: tick = 1'b1;
         DTCU_CK_EXT: tick = ev;
         DTCU_CK_PULSE: tick = lvl;
         default: tick = 1'b0;
      endcase
   endfunction

   logic a_edge, b_edge, b_rise, capture_mode, b_cap, a_cap;
   // pin inputs are taken as synchronous; a pulse of one clock suffices
   assign a_edge = edge_hit(timer_pin_a_i, pin_a_prev_q, aedg);
   assign b_edge = edge_hit(timer_pin_b_i, pin_b_prev_q, bedg);
   assign b_rise = timer_pin_b_i & ~pin_b_prev_q;
   assign capture_mode = (mode == DTCU_M2) || (mode == DTCU_M4);
   assign a_cap = en && (mode == DTCU_M2) && a_edge;
   assign b_cap = en && capture_mode && b_edge;

   // pin b as event source in DTCU_M1, DTCU_M3 and DTCU_M1A without ptse, and for counter one in DTCU_M4
   logic b_evt_ok;
   assign b_evt_ok = (mode == DTCU_M1) || (mode == DTCU_M3) ||
                     ((mode == DTCU_M1A) && !ptse);

   logic t1, t2, run1, run2, uf1, uf2;
   assign run1 = en && (!capture_mode || armed_q);
   assign t1 = run1 && tick(ck1, b_edge & (b_evt_ok | (mode == DTCU_M4)),
                            timer_pin_b_i)
               && !((mode == DTCU_M2) && (ck1 == DTCU_CK_EXT ||
                                          ck1 == DTCU_CK_PULSE));
   assign t2 = run1 && tick(ck2, b_edge & b_evt_ok, timer_pin_b_i)
               && !((mode == DTCU_M4) && (ck2 == DTCU_CK_EXT ||
                                          ck2 == DTCU_CK_PULSE));
   assign uf1 = t1 && (down_counter_one_q == ZERO16);
   assign uf2 = t2 && (down_counter_two_q == ZERO16);

   always_ff @(posedge ref_clk_i) begin
      pin_a_prev_q <= timer_pin_a_i;
      pin_b_prev_q <= timer_pin_b_i;
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i || !en || !capture_mode) begin
         armed_q <= 1'b0;
      end else if (b_edge || (mode == DTCU_M2 && a_edge)) begin
         armed_q <= 1'b1;
      end
   end

   // bus: one wait cycle, answer on the second edge
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         bus_q <= DTCU_BUS_IDLE;
      end else begin
         case (bus_q)
            DTCU_BUS_IDLE: if (avs_read_i || avs_write_i) bus_q <= DTCU_BUS_ACK;
            DTCU_BUS_ACK: bus_q <= DTCU_BUS_IDLE;
            default: bus_q <= DTCU_BUS_IDLE;
         endcase
      end
   end
   assign wr_acc = avs_write_i && (bus_q == DTCU_BUS_ACK);
   assign rd_acc = avs_read_i && (bus_q == DTCU_BUS_IDLE);

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= !((bus_q == DTCU_BUS_IDLE) &&
                                (avs_read_i || avs_write_i));
      end
   end

   logic wr_lo;
   assign wr_lo = wr_acc && (avs_byteenable_i[1:0] == 2'b11);

   // counter one: no reset, stores garbage at power-up
   always_ff @(posedge ref_clk_i) begin
      if (wr_lo && avs_address_i == OFS_CNT1) begin
         down_counter_one_q <= avs_writedata_i[15:0];
      end else if (a_cap && aen) begin
         down_counter_one_q <= PRESET_VAL;
      end else if (uf1 && mode != DTCU_M2) begin
         down_counter_one_q <= capture_reload_a_q;
      end else if (t1) begin
         down_counter_one_q <= down_counter_one_q - 16'h0001;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (wr_lo && avs_address_i == OFS_CNT2) begin
         down_counter_two_q <= avs_writedata_i[15:0];
      end else if (b_cap && ben && mode == DTCU_M4) begin
         down_counter_two_q <= PRESET_VAL;
      end else if (uf2 && mode == DTCU_M3) begin
         down_counter_two_q <= capture_reload_b_q;
      end else if (t2) begin
         down_counter_two_q <= down_counter_two_q - 16'h0001;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (a_cap) begin
         capture_reload_a_q <= down_counter_one_q;
      end else if (en && wr_lo && avs_address_i == OFS_CRA) begin
         capture_reload_a_q <= avs_writedata_i[15:0];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (b_cap) begin
         capture_reload_b_q <= (mode == DTCU_M4) ? down_counter_two_q
                                                : down_counter_one_q;
      end else if (en && wr_lo && avs_address_i == OFS_CRB) begin
         capture_reload_b_q <= avs_writedata_i[15:0];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         ckc_q <= CKC_RST;
         irq_enable_q <= IEN_RST;
      end else if (wr_acc && avs_byteenable_i[0]) begin
         if (avs_address_i == OFS_CKC) ckc_q <= avs_writedata_i[7:0];
         if (avs_address_i == OFS_ICTRL) begin
            irq_enable_q <= avs_writedata_i[IC_IEN_LSB +: 4];
         end
      end
   end

   // pin a level lives in the mode register so software sets it pre-start
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         mode_control_reg_q <= MCTRL_RST;
      end else if (wr_acc && avs_address_i == OFS_MCTRL &&
                   avs_byteenable_i[1:0] == 2'b11) begin
         mode_control_reg_q <= avs_writedata_i[9:0];
      end else if (uf1 && aen && mode != DTCU_M2) begin
         mode_control_reg_q[MC_AOUT] <= !mode_control_reg_q[MC_AOUT];
      end
   end

   // event sets win over clears in the same cycle
   logic [3:0] set_ev, clr;
   always_comb begin
      set_ev = 4'h0;
      set_ev[0] = (mode == DTCU_M2) ? a_cap : uf1;
      set_ev[1] = capture_mode ? b_cap : 1'b0;
      set_ev[2] = (mode == DTCU_M2) && uf1;
      set_ev[3] = uf2;
      clr = (wr_acc && avs_address_i == OFS_ICLR && avs_byteenable_i[0])
            ? avs_writedata_i[3:0] : 4'h0;
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         pending_q <= PND_RST;
      end else begin
         pending_q <= (pending_q & ~clr) | set_ev;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         irq_line_a_o <= 1'b0;
         irq_line_b_o <= 1'b0;
         timer_pin_a_o <= 1'b0;
         timer_pin_a_oe_o <= 1'b0;
      end else begin
         irq_line_a_o <= |(pending_q[2:0] & irq_enable_q[2:0]);
         irq_line_b_o <= pending_q[3] & irq_enable_q[3];
         timer_pin_a_o <= mode_control_reg_q[MC_AOUT];
         timer_pin_a_oe_o <= (mode != DTCU_M2) &&
                             !((mode == DTCU_M1 || mode == DTCU_M1A) && !aen);
      end
   end

   logic [31:0] rd_d;
   always_comb begin
      case (avs_address_i)
         OFS_CNT1: rd_d = {16'h0000, down_counter_one_q};
         OFS_CRA: rd_d = {16'h0000, capture_reload_a_q};
         OFS_CRB: rd_d = {16'h0000, capture_reload_b_q};
         OFS_CNT2: rd_d = {16'h0000, down_counter_two_q};
         OFS_CKC: rd_d = {24'h000000, ckc_q};
         OFS_MCTRL: rd_d = {22'h000000, mode_control_reg_q};
         OFS_ICTRL: rd_d = {24'h000000, irq_enable_q, pending_q};
         default: rd_d = RD_UNMAPPED;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         avs_readdata_o <= RD_UNMAPPED;
      end else if (rd_acc) begin
         avs_readdata_o <= rd_d;
      end
   end

   property p_uf1_flag;
      @(posedge ref_clk_i) disable iff (srst_i)
      (uf1 && mode == DTCU_M4) |=> pending_q[0];
   endproperty
   a_uf1_flag: assert property (p_uf1_flag)
      else $error("flag a not set on underflow");

   property p_reload;
      @(posedge ref_clk_i) disable iff (srst_i)
      (uf1 && mode == DTCU_M4 && !(wr_lo && avs_address_i == OFS_CNT1))
      |=> down_counter_one_q == $past(capture_reload_a_q);
   endproperty
   a_reload: assert property (p_reload)
      else $error("counter one not reloaded");

   property p_irqb;
      @(posedge ref_clk_i) disable iff (srst_i)
      (pending_q[3] && irq_enable_q[3]) |=> irq_line_b_o;
   endproperty
   a_irqb: assert property (p_irqb)
      else $error("line b not raised");

   property p_irqa;
      @(posedge ref_clk_i) disable iff (srst_i)
      (|(pending_q[2:0] & irq_enable_q[2:0])) |=> irq_line_a_o;
   endproperty
   a_irqa: assert property (p_irqa)
      else $error("line a not raised");

   property p_flagb;
      @(posedge ref_clk_i) disable iff (srst_i)
      b_cap |=> pending_q[1];
   endproperty
   a_flagb: assert property (p_flagb)
      else $error("flag b not set on capture");

   property p_capb;
      @(posedge ref_clk_i) disable iff (srst_i)
      (b_cap && mode == DTCU_M4)
      |=> capture_reload_b_q == $past(down_counter_two_q);
   endproperty
   a_capb: assert property (p_capb)
      else $error("counter two not captured");

   property p_preset;
      @(posedge ref_clk_i) disable iff (srst_i)
      (b_cap && ben && mode == DTCU_M4 &&
       !(wr_lo && avs_address_i == OFS_CNT2))
      |=> down_counter_two_q == PRESET_VAL;
   endproperty
   a_preset: assert property (p_preset)
      else $error("counter two not preset");

   property p_toggle;
      @(posedge ref_clk_i) disable iff (srst_i)
      (uf1 && aen && mode == DTCU_M4 &&
       !(wr_acc && avs_address_i == OFS_MCTRL))
      |=> mode_control_reg_q[MC_AOUT] != $past(mode_control_reg_q[MC_AOUT]);
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("pin a level not inverted");

   property p_stop2;
      @(posedge ref_clk_i) disable iff (srst_i)
      (mode == DTCU_M4 && (ck2 == DTCU_CK_EXT || ck2 == DTCU_CK_PULSE) &&
       !b_cap && !(wr_lo && avs_address_i == OFS_CNT2))
      |=> $stable(down_counter_two_q);
   endproperty
   a_stop2: assert property (p_stop2)
      else $error("counter two moved while stopped");

   property p_crgate;
      @(posedge ref_clk_i) disable iff (srst_i)
      (!en && !a_cap && wr_lo && avs_address_i == OFS_CRA)
      |=> $stable(capture_reload_a_q);
   endproperty
   a_crgate: assert property (p_crgate)
      else $error("reload a written while disabled");
endmodule

/* File: bench/dtcu_pad_model.sv */
`timescale 1ns/1ps
module dtcu_pad_model (
   input wire logic clk_i,
   input wire logic pin_a_o_i,
   input wire logic pin_a_oe_i,
   output logic pin_b_o,
   output logic pad_a_o
);
   // a released pad is pulled low, so a stale level cannot pass
   assign pad_a_o = pin_a_oe_i ? pin_a_o_i : 1'b0;
   initial pin_b_o = 1'b0;
   task automatic drive_b(input logic lvl);
      @(posedge clk_i);
      pin_b_o <= lvl;
      repeat (3) @(posedge clk_i);
   endtask
endmodule

/* File: bench/dtcu_top_bench.sv */
`timescale 1ns/1ps
module dtcu_top_bench;
   import dtcu_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [5:0] adr = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic wait_o, pa_o, pa_oe, irq_a, irq_b, pin_b, pad_a;
   logic [31:0] v, w;
   int fail_count = 0;
   int checked = 0;
   int cyc = 0;
   always #5 clk = ~clk;
   dtcu_top i_dtcu_top (.ref_clk_i(clk), .srst_i(srst),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
      .timer_pin_a_i(pad_a), .timer_pin_b_i(pin_b),
      .timer_pin_a_o(pa_o), .timer_pin_a_oe_o(pa_oe),
      .irq_line_a_o(irq_a), .irq_line_b_o(irq_b));
   dtcu_pad_model i_dtcu_pad_model (.clk_i(clk), .pin_a_o_i(pa_o),
      .pin_a_oe_i(pa_oe), .pin_b_o(pin_b), .pad_a_o(pad_a));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         print_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wdat <= d;
      wr <= 1'b1;
      do @(posedge clk); while (wait_o !== 1'b0);
      wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge clk);
      adr <= a;
      rd <= 1'b1;
      do @(posedge clk); while (wait_o !== 1'b0);
      d = rdat;
      rd <= 1'b0;
   endtask
   task automatic wait_irq_a();
      int n;
      n = 0;
      while (irq_a !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic t_reset();
      #1;
      chk("waitreq", 32'(wait_o), 32'h1);
      chk("irq_ab", {30'h0, irq_a, irq_b}, 32'h0);
      chk("pin_a_oe", 32'(pa_oe), 32'h0);
      bus_rd(OFS_MCTRL, v);
      chk("mctrl", v, 32'h0);
      bus_rd(6'h10, v);
      chk("unmapped", v, RD_UNMAPPED);
      $display("test reset done");
   endtask
   task automatic t_wr_gate();
      bus_wr(OFS_MCTRL, 32'h0000000C);
      bus_wr(OFS_CRA, 32'h00000055);
      bus_wr(OFS_MCTRL, 32'h00000004);
      bus_wr(OFS_CRA, 32'h000000AA);
      bus_rd(OFS_CRA, v);
      chk("cra_kept", {16'h0, v[15:0]}, 32'h55);
      $display("test write gate done");
   endtask
   task automatic t_toggle();
      bus_wr(OFS_MCTRL, 32'h0000011C);
      bus_wr(OFS_CNT1, 32'h00000004);
      bus_wr(OFS_CRA, 32'h00000004);
      bus_wr(OFS_CNT2, 32'h00000000);
      // capture mode: a falling pin b edge arms the counters
      i_dtcu_pad_model.drive_b(1'b1);
      i_dtcu_pad_model.drive_b(1'b0);
      bus_wr(OFS_ICLR, 32'h0000000F);
      bus_wr(OFS_ICTRL, 32'h00000010);
      chk("pad_start", 32'(pad_a), 32'h1);
      bus_wr(OFS_CKC, 32'h00000001);
      wait_irq_a();
      #1;
      chk("irq_a", 32'(irq_a), 32'h1);
      chk("pad_inv", 32'(pad_a), 32'h0);
      bus_wr(OFS_CKC, 32'h00000000);
      bus_rd(OFS_CNT1, v);
      chk("reload", {16'h0, v[15:3], 3'b000}, 32'h0);
      bus_rd(OFS_ICTRL, v);
      chk("pending", {24'h0, v[7:0]}, 32'h11);
      bus_wr(OFS_ICLR, 32'h00000001);
      repeat (2) @(posedge clk);
      #1;
      chk("irq_clr", 32'(irq_a), 32'h0);
      $display("test toggle done");
   endtask
   task automatic t_capture();
      bus_wr(OFS_MCTRL, 32'h00000000);
      bus_wr(OFS_MCTRL, 32'h0000002C);
      bus_wr(OFS_ICLR, 32'h0000000F);
      bus_wr(OFS_ICTRL, 32'h00000020);
      bus_wr(OFS_CNT2, 32'h00000100);
      bus_wr(OFS_CKC, 32'h00000010);
      i_dtcu_pad_model.drive_b(1'b1);
      bus_rd(OFS_ICTRL, v);
      chk("no_cap", {31'h0, v[1]}, 32'h0);
      bus_rd(OFS_CNT2, v);
      chk("idle", {16'h0, v[15:0]}, 32'h100);
      i_dtcu_pad_model.drive_b(1'b0);
      wait_irq_a();
      #1;
      chk("irq_cap", 32'(irq_a), 32'h1);
      bus_rd(OFS_CRB, v);
      chk("crb", {16'h0, v[15:0]}, 32'h100);
      bus_rd(OFS_CNT2, v);
      chk("preset", {24'h0, v[15:8]}, 32'hFF);
      bus_wr(OFS_CKC, 32'h00000020);
      bus_rd(OFS_CNT2, v);
      repeat (5) @(posedge clk);
      bus_rd(OFS_CNT2, w);
      chk("stopped", w, v);
      bus_wr(OFS_ICTRL, 32'h00000080);
      bus_wr(OFS_CNT2, 32'h00000003);
      bus_wr(OFS_CKC, 32'h00000010);
      repeat (10) @(posedge clk);
      #1;
      chk("irq_b", 32'(irq_b), 32'h1);
      $display("test capture done");
   endtask
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_wr_gate();
      t_toggle();
      t_capture();
      print_verdict();
   end
endmodule
